// ---- core/si_ctrl_pkg.sv ----
// Constants for the paged system integrity control/status register.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package si_ctrl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // Byte address of the single paged register
    localparam logic [ADDR_W-1:0] INTEGRITY_CTRL_STATUS_OFS = 8'h40;

    // Fields common to both pages
    localparam int PAGE_BIT = 7;

    // Page 0 fields
    localparam int SUPPLY_WARN_IRQ_ENABLE_BIT = 6;
    localparam int SUPPLY_WARN_FLAG_BIT = 5;
    localparam int LOW_VOLTAGE_RESET_FLAG_BIT = 4;
    localparam int CLOCK_FAIL_IRQ_ENABLE_BIT = 2;
    localparam int CLOCK_FAIL_DETECTED_BIT = 1;
    localparam int WATCHDOG_RESET_FLAG_BIT = 0;

    // Page 1 fields
    localparam int VCO_GROUND_SELECT_BIT = 5;
    localparam int PLL_LOCK_BIT = 4;
    localparam int PLL_ENABLE_BIT = 3;
    localparam int CLOCK_SOURCE_SELECT_BIT = 1;

    // Reset values of the fields cleared by system reset
    localparam logic PAGE_RST = 1'b0;
    localparam logic SUPPLY_WARN_IRQ_ENABLE_RST = 1'b0;
    localparam logic CLOCK_FAIL_IRQ_ENABLE_RST = 1'b0;
    localparam logic CLOCK_FAIL_DETECTED_RST = 1'b0;
    localparam logic VCO_GROUND_SELECT_RST = 1'b0;
    localparam logic PLL_ENABLE_RST = 1'b0;
    localparam logic CLOCK_SOURCE_SELECT_RST = 1'b0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : si_ctrl_pkg

// ---- core/system_integrity_ctrl_status.sv ----
// Paged system integrity control/status register behind an AXI4-Lite
// slave, with supply-warning and clock-failure event logic.
// Assumes one clock (aclk) and synchronous active-low reset; monitor
// inputs from analog or pin sources are resynchronised here.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module system_integrity_ctrl_status (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [si_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [si_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [si_ctrl_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [si_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [si_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Monitors and reset-source indications
    input wire logic supply_below_warn,
    input wire logic main_osc_stopped,
    input wire logic pll_locked,
    input wire logic lvd_reset_event,
    input wire logic wdg_reset_event,
    input wire logic lvd_option_enable,
    input wire logic pll_clock_option,
    input wire logic in_circuit_debug_session,
    input wire logic halt_mode,
    input wire logic supply_warn_irq_ack,
    // Controls and requests toward the system
    output logic supply_warn_irq,
    output logic clock_fail_irq,
    output logic wake_request,
    output logic pll_enable_out,
    output logic clock_detector_enable,
    output logic safe_osc_enable,
    output logic vco_ground_select_out,
    output logic pll_clock_selected
);
    import si_ctrl_pkg::*;

    // Two-flop synchronisers for asynchronous inputs
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic supply_below_s, osc_stopped_s, pll_locked_s, icc_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {in_circuit_debug_session, pll_locked,
                        main_osc_stopped, supply_below_warn};
            sync2_r <= sync1_r;
        end
    end

    assign {icc_s, pll_locked_s, osc_stopped_s, supply_below_s} = sync2_r;

    // Bus state
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic wlane_r, wlane_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    // Register state
    logic page_r, page_nxt;
    logic warn_ie_r, warn_ie_nxt;
    logic warn_flag_r, warn_flag_nxt;
    logic warn_pend_r, warn_pend_nxt;
    logic low_voltage_reset_flag_r, low_voltage_reset_flag_nxt;
    logic watchdog_reset_flag_r, watchdog_reset_flag_nxt;
    logic cf_ie_r, cf_ie_nxt;
    logic cf_det_r, cf_det_nxt;
    logic vco_r, vco_nxt;
    logic lock_r, lock_nxt;
    logic pll_enable_r, pll_enable_nxt;
    logic clock_source_select_r, clock_source_select_nxt;
    logic icc_d_r, icc_d_nxt;
    logic cf_irq_r, cf_irq_nxt;
    logic warn_irq_r, warn_irq_nxt;
    logic wake_r, wake_nxt;
    logic clksel_out_r, clksel_out_nxt;
    logic safe_osc_r, safe_osc_nxt;
    logic wr_fire, wr_hit, rd_fire, rd_hit, rd_clear;
    logic [7:0] readback;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == INTEGRITY_CTRL_STATUS_OFS);
    endfunction : addr_hit
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_hit = wr_fire && addr_hit(waddr_r) && wlane_r;
    assign rd_fire = s_axi_arvalid && arready_r;
    assign rd_hit = rd_fire && addr_hit(s_axi_araddr);
    // Reading page 0 is what clears the clock-fail flag
    assign rd_clear = rd_hit && !page_r;

    // One address, content depends on page
    always_comb begin
        readback = 8'h00;
        readback[PAGE_BIT] = page_r;
        if (!page_r) begin
            readback[SUPPLY_WARN_IRQ_ENABLE_BIT] = warn_ie_r;
            readback[SUPPLY_WARN_FLAG_BIT] = warn_flag_r;
            readback[LOW_VOLTAGE_RESET_FLAG_BIT] = low_voltage_reset_flag_r;
            readback[CLOCK_FAIL_IRQ_ENABLE_BIT] = cf_ie_r;
            // Stored flag hidden while PLL is off
            readback[CLOCK_FAIL_DETECTED_BIT] = cf_det_r && pll_enable_r;
            readback[WATCHDOG_RESET_FLAG_BIT] = watchdog_reset_flag_r;
        end else begin
            readback[VCO_GROUND_SELECT_BIT] = vco_r;
            readback[PLL_LOCK_BIT] = lock_r;
            readback[PLL_ENABLE_BIT] = pll_enable_r;
            readback[CLOCK_SOURCE_SELECT_BIT] = clock_source_select_r;
        end
    end
    // AXI4-Lite handshakes; address and data may come in either order
    always_comb begin
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        waddr_nxt = waddr_r;
        wbyte_nxt = wbyte_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && awready_r) begin
            aw_held_nxt = 1'b1;
            awready_nxt = 1'b0;
            waddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_held_nxt = 1'b1;
            wready_nxt = 1'b0;
            wbyte_nxt = s_axi_wdata[7:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_hit(waddr_r) ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
        end
        if (rd_fire) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_hit ? {24'h000000, readback} : 32'h00000000;
            rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= '0;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            waddr_r <= waddr_nxt;
            wbyte_r <= wbyte_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // Register fields and event logic
    always_comb begin
        page_nxt = page_r;
        warn_ie_nxt = warn_ie_r;
        warn_flag_nxt = supply_below_s;
        warn_pend_nxt = warn_pend_r;
        low_voltage_reset_flag_nxt = low_voltage_reset_flag_r;
        watchdog_reset_flag_nxt = watchdog_reset_flag_r;
        cf_ie_nxt = cf_ie_r;
        cf_det_nxt = cf_det_r;
        vco_nxt = vco_r;
        lock_nxt = pll_locked_s && pll_enable_r;
        pll_enable_nxt = pll_enable_r;
        clock_source_select_nxt = clock_source_select_r;
        icc_d_nxt = icc_s;
        if (wr_hit) begin
            page_nxt = wbyte_r[PAGE_BIT];
            if (!page_r) begin
                // Reserved bits are simply not stored
                warn_ie_nxt = wbyte_r[SUPPLY_WARN_IRQ_ENABLE_BIT];
                cf_ie_nxt = wbyte_r[CLOCK_FAIL_IRQ_ENABLE_BIT];
                // Reset-cause flags only clear, never set, by software
                if (!wbyte_r[LOW_VOLTAGE_RESET_FLAG_BIT]) begin
                    low_voltage_reset_flag_nxt = 1'b0;
                end
                if (!wbyte_r[WATCHDOG_RESET_FLAG_BIT]) begin
                    watchdog_reset_flag_nxt = 1'b0;
                end
            end else begin
                vco_nxt = wbyte_r[VCO_GROUND_SELECT_BIT];
                pll_enable_nxt = wbyte_r[PLL_ENABLE_BIT];
                clock_source_select_nxt = wbyte_r[CLOCK_SOURCE_SELECT_BIT];
                // Keep PLL on while it clocks the core
                if (clock_source_select_r && clock_source_select_nxt) begin
                    pll_enable_nxt = 1'b1;
                end
                // Refuse selecting a PLL that is off
                if (!pll_enable_nxt) begin
                    clock_source_select_nxt = 1'b0;
                end
            end
        end
        // Option byte selects the PLL clock and keeps the PLL running
        if (pll_clock_option) begin
            clock_source_select_nxt = 1'b1;
            pll_enable_nxt = 1'b1;
        end
        // Session start forces a clock independent of the input clock
        if (icc_s && !icc_d_r) begin
            vco_nxt = 1'b1;
            pll_enable_nxt = 1'b1;
            clock_source_select_nxt = 1'b1;
        end
        // Pending supply request; a new toggle beats the ack
        if (supply_warn_irq_ack) begin
            warn_pend_nxt = 1'b0;
        end
        if (warn_ie_r && (supply_below_s != warn_flag_r)) begin
            warn_pend_nxt = 1'b1;
        end
        // Read clears only after the oscillator is back; set wins
        if (rd_clear && !osc_stopped_s) begin
            cf_det_nxt = 1'b0;
        end
        if (osc_stopped_s && pll_enable_r && !halt_mode) begin
            cf_det_nxt = 1'b1;
        end
        if (!pll_enable_r) begin
            cf_det_nxt = 1'b0;
        end
        // Reset causes survive system reset while lvd_option_enable is set, see clocked process
        if (wdg_reset_event) begin
            watchdog_reset_flag_nxt = 1'b1;
        end
        if (lvd_reset_event) begin
            low_voltage_reset_flag_nxt = 1'b1;
            watchdog_reset_flag_nxt = 1'b0;
        end
    end
    // Registered outputs computed from next state
    always_comb begin
        warn_irq_nxt = warn_pend_nxt;
        cf_irq_nxt = cf_ie_nxt && cf_det_nxt && pll_enable_nxt;
        // Halt masks clock-fail wakeup; supply warning still wakes
        wake_nxt = warn_pend_nxt ||
                   (cf_irq_nxt && !halt_mode);
        clksel_out_nxt = pll_clock_option ||
                         (clock_source_select_nxt && pll_enable_nxt);
        safe_osc_nxt = pll_enable_nxt && !halt_mode;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_r <= PAGE_RST;
            warn_ie_r <= SUPPLY_WARN_IRQ_ENABLE_RST;
            warn_flag_r <= 1'b0;
            warn_pend_r <= 1'b0;
            cf_ie_r <= CLOCK_FAIL_IRQ_ENABLE_RST;
            cf_det_r <= CLOCK_FAIL_DETECTED_RST;
            vco_r <= VCO_GROUND_SELECT_RST;
            lock_r <= 1'b0;
            pll_enable_r <= PLL_ENABLE_RST;
            clock_source_select_r <= CLOCK_SOURCE_SELECT_RST;
            icc_d_r <= 1'b0;
            warn_irq_r <= 1'b0;
            cf_irq_r <= 1'b0;
            wake_r <= 1'b0;
            clksel_out_r <= 1'b0;
            safe_osc_r <= 1'b0;
        end else begin
            page_r <= page_nxt;
            warn_ie_r <= warn_ie_nxt;
            warn_flag_r <= warn_flag_nxt;
            warn_pend_r <= warn_pend_nxt;
            cf_ie_r <= cf_ie_nxt;
            cf_det_r <= cf_det_nxt;
            vco_r <= vco_nxt;
            lock_r <= lock_nxt;
            pll_enable_r <= pll_enable_nxt;
            clock_source_select_r <= clock_source_select_nxt;
            icc_d_r <= icc_d_nxt;
            warn_irq_r <= warn_irq_nxt;
            cf_irq_r <= cf_irq_nxt;
            wake_r <= wake_nxt;
            clksel_out_r <= clksel_out_nxt;
            safe_osc_r <= safe_osc_nxt;
        end
    end
    // Cause flags outlive reset unless the detector option is off
    always_ff @(posedge aclk) begin
        if (!aresetn && !lvd_option_enable) begin
            low_voltage_reset_flag_r <= 1'b0;
            watchdog_reset_flag_r <= 1'b0;
        end else if (!aresetn) begin
            // Causes still recorded while reset is asserted
            low_voltage_reset_flag_r <= low_voltage_reset_flag_r || lvd_reset_event;
            watchdog_reset_flag_r <= lvd_reset_event ? 1'b0 : (watchdog_reset_flag_r || wdg_reset_event);
        end else begin
            low_voltage_reset_flag_r <= low_voltage_reset_flag_nxt;
            watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign supply_warn_irq = warn_irq_r;
    assign clock_fail_irq = cf_irq_r;
    assign wake_request = wake_r;
    assign pll_enable_out = pll_enable_r;
    assign clock_detector_enable = pll_enable_r;
    assign safe_osc_enable = safe_osc_r;
    assign vco_ground_select_out = vco_r;
    assign pll_clock_selected = clksel_out_r;

endmodule : system_integrity_ctrl_status

// ---- tb/system_integrity_ctrl_status_asserts.sv ----
// Port-level checks for the paged integrity register block.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module system_integrity_ctrl_status_asserts
import si_ctrl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [si_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [si_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic pll_clock_option,
    input wire logic in_circuit_debug_session,
    input wire logic halt_mode,
    input wire logic supply_warn_irq,
    input wire logic clock_fail_irq,
    input wire logic wake_request,
    input wire logic pll_enable_out,
    input wire logic clock_detector_enable,
    input wire logic safe_osc_enable,
    input wire logic vco_ground_select_out,
    input wire logic pll_clock_selected
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ckd;
        clock_detector_enable == pll_enable_out;
    endproperty
    a_ckd: assert property (p_ckd)
        else $error("clock detector enable differs from pll enable");
    property p_cf_irq;
        clock_fail_irq |-> pll_enable_out;
    endproperty
    a_cf_irq: assert property (p_cf_irq)
        else $error("clock fail irq while pll off");
    property p_sel;
        pll_clock_selected && !pll_clock_option |-> pll_enable_out;
    endproperty
    a_sel: assert property (p_sel)
        else $error("pll clock selected while pll off");
    property p_dbg;
        $rose(in_circuit_debug_session) |-> ##[1:6] vco_ground_select_out;
    endproperty
    a_dbg: assert property (p_dbg)
        else $error("debug session did not force vco select");
    property p_wake;
        supply_warn_irq |-> wake_request;
    endproperty
    a_wake: assert property (p_wake)
        else $error("pending supply request without wake");
    property p_halt;
        halt_mode ##1 halt_mode |-> !safe_osc_enable;
    endproperty
    a_halt: assert property (p_halt)
        else $error("safe oscillator running in halt");
    property p_safe;
        safe_osc_enable |-> pll_enable_out && !$past(halt_mode);
    endproperty
    a_safe: assert property (p_safe)
        else $error("safe oscillator without pll enable");
    property p_bad_rd;
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr != INTEGRITY_CTRL_STATUS_OFS
            |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR
            && s_axi_rdata == '0;
    endproperty
    a_bad_rd: assert property (p_bad_rd)
        else $error("unmapped read not answered with error");
    property p_rsv;
        s_axi_rvalid |-> s_axi_rdata[31:8] == '0 && (s_axi_rdata[7] ?
            s_axi_rdata[6] == 1'b0 && s_axi_rdata[2] == 1'b0
            && s_axi_rdata[0] == 1'b0 : s_axi_rdata[3] == 1'b0);
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved read bit not zero");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr)
        else $error("write response late");

    c_cf: cover property (clock_fail_irq);
    c_sw: cover property (supply_warn_irq && wake_request);
    c_sel: cover property (pll_clock_selected && !pll_clock_option);
endmodule : system_integrity_ctrl_status_asserts

bind system_integrity_ctrl_status system_integrity_ctrl_status_asserts u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .pll_clock_option, .in_circuit_debug_session, .halt_mode,
    .supply_warn_irq, .clock_fail_irq, .wake_request, .pll_enable_out,
    .clock_detector_enable, .safe_osc_enable, .vco_ground_select_out,
    .pll_clock_selected
);

// ---- tb/tb_system_integrity_ctrl_status.sv ----
// Self-checking bench for the paged integrity register over AXI4-Lite.
// Assumes the reset-cause inputs are held during the bench's resets.
`timescale 1ns/1ps
module tb_system_integrity_ctrl_status;
    import si_ctrl_pkg::*;
    localparam logic [ADDR_W-1:0] RA = INTEGRITY_CTRL_STATUS_OFS;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic supply_below_warn = 1'b0, main_osc_stopped = 1'b0;
    logic pll_locked = 1'b0, wdg_reset_event = 1'b0;
    // Reset cause present from power up so the flags start defined
    logic lvd_reset_event = 1'b1, lvd_option_enable = 1'b1;
    logic pll_clock_option = 1'b0, in_circuit_debug_session = 1'b0;
    logic halt_mode = 1'b0, supply_warn_irq_ack = 1'b0;
    logic supply_warn_irq, clock_fail_irq, wake_request, pll_enable_out;
    logic clock_detector_enable, safe_osc_enable, vco_ground_select_out;
    logic pll_clock_selected;
    int miscompares = 0;
    int num_checks = 0;

    system_integrity_ctrl_status DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .supply_below_warn, .main_osc_stopped,
        .pll_locked, .lvd_reset_event, .wdg_reset_event, .lvd_option_enable,
        .pll_clock_option, .in_circuit_debug_session, .halt_mode,
        .supply_warn_irq_ack, .supply_warn_irq, .clock_fail_irq,
        .wake_request, .pll_enable_out, .clock_detector_enable,
        .safe_osc_enable, .vco_ground_select_out, .pll_clock_selected
    );

    initial begin
        forever #10 aclk = ~aclk;
    end

    task end_sim;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chkb

    task wreg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Either channel may be taken first; each drops on its own ready
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask : wreg

    task rreg(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", {24'h0, ed}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask : rreg

    task do_reset(input logic l, input logic w);
        @(posedge aclk);
        aresetn <= 1'b0;
        lvd_reset_event <= l;
        wdg_reset_event <= w;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        lvd_reset_event <= 1'b0;
        wdg_reset_event <= 1'b0;
    endtask : do_reset

    task ack;
        @(posedge aclk);
        supply_warn_irq_ack <= 1'b1;
        @(posedge aclk);
        supply_warn_irq_ack <= 1'b0;
    endtask : ack

    initial begin
        #50us;
        miscompares++;
        end_sim();
    end

    initial begin
        do_reset(1'b1, 1'b0);
        rreg(RA, 8'h10, RESP_OKAY);
        wreg(RA, 8'h54, RESP_OKAY);
        rreg(RA, 8'h54, RESP_OKAY);
        do_reset(1'b0, 1'b1);
        rreg(RA, 8'h11, RESP_OKAY);
        wreg(RA, 8'h00, RESP_OKAY);
        rreg(RA, 8'h00, RESP_OKAY);
        do_reset(1'b0, 1'b1);
        rreg(RA, 8'h01, RESP_OKAY);
        do_reset(1'b1, 1'b0);
        rreg(RA, 8'h10, RESP_OKAY);
        rreg(8'h44, 8'h00, RESP_SLVERR);
        wreg(8'h44, 8'h80, RESP_SLVERR);
        rreg(RA, 8'h10, RESP_OKAY);
        wreg(RA, 8'h50, RESP_OKAY);
        supply_below_warn <= 1'b1;
        repeat (8) @(posedge aclk);
        chkb("sw_irq", 1'b1, supply_warn_irq);
        chkb("wake", 1'b1, wake_request);
        rreg(RA, 8'h70, RESP_OKAY);
        ack();
        repeat (2) @(posedge aclk);
        chkb("sw_irq", 1'b0, supply_warn_irq);
        halt_mode <= 1'b1;
        supply_below_warn <= 1'b0;
        repeat (8) @(posedge aclk);
        chkb("wake", 1'b1, wake_request);
        ack();
        halt_mode <= 1'b0;
        rreg(RA, 8'h50, RESP_OKAY);
        wreg(RA, 8'h80, RESP_OKAY);
        rreg(RA, 8'h80, RESP_OKAY);
        wreg(RA, 8'h82, RESP_OKAY);
        rreg(RA, 8'h80, RESP_OKAY);
        chkb("pll_sel", 1'b0, pll_clock_selected);
        wreg(RA, 8'h88, RESP_OKAY);
        chkb("pll_en", 1'b1, pll_enable_out);
        chkb("ckd_en", 1'b1, clock_detector_enable);
        pll_locked <= 1'b1;
        repeat (6) @(posedge aclk);
        rreg(RA, 8'h98, RESP_OKAY);
        wreg(RA, 8'h8A, RESP_OKAY);
        rreg(RA, 8'h9A, RESP_OKAY);
        chkb("pll_sel", 1'b1, pll_clock_selected);
        wreg(RA, 8'h82, RESP_OKAY);
        rreg(RA, 8'h9A, RESP_OKAY);
        wreg(RA, 8'h88, RESP_OKAY);
        rreg(RA, 8'h98, RESP_OKAY);
        // Leave page 1 with the pll kept on, then arm the clock-fail irq
        wreg(RA, 8'h08, RESP_OKAY);
        wreg(RA, 8'h04, RESP_OKAY);
        main_osc_stopped <= 1'b1;
        repeat (8) @(posedge aclk);
        chkb("cf_irq", 1'b1, clock_fail_irq);
        chkb("wake", 1'b1, wake_request);
        rreg(RA, 8'h06, RESP_OKAY);
        rreg(RA, 8'h06, RESP_OKAY);
        main_osc_stopped <= 1'b0;
        repeat (8) @(posedge aclk);
        rreg(RA, 8'h06, RESP_OKAY);
        rreg(RA, 8'h04, RESP_OKAY);
        halt_mode <= 1'b1;
        main_osc_stopped <= 1'b1;
        repeat (8) @(posedge aclk);
        chkb("cf_irq", 1'b0, clock_fail_irq);
        chkb("safe_osc", 1'b0, safe_osc_enable);
        main_osc_stopped <= 1'b0;
        // Let the synchronised stop clear before halt ends
        repeat (4) @(posedge aclk);
        halt_mode <= 1'b0;
        repeat (8) @(posedge aclk);
        chkb("safe_osc", 1'b1, safe_osc_enable);
        rreg(RA, 8'h04, RESP_OKAY);
        main_osc_stopped <= 1'b1;
        repeat (8) @(posedge aclk);
        wreg(RA, 8'h84, RESP_OKAY);
        wreg(RA, 8'h00, RESP_OKAY);
        chkb("cf_irq", 1'b0, clock_fail_irq);
        chkb("pll_en", 1'b0, pll_enable_out);
        rreg(RA, 8'h04, RESP_OKAY);
        main_osc_stopped <= 1'b0;
        in_circuit_debug_session <= 1'b1;
        repeat (8) @(posedge aclk);
        chkb("vco", 1'b1, vco_ground_select_out);
        chkb("pll_sel", 1'b1, pll_clock_selected);
        wreg(RA, 8'h80, RESP_OKAY);
        rreg(RA, 8'hBA, RESP_OKAY);
        wreg(RA, 8'h88, RESP_OKAY);
        rreg(RA, 8'h98, RESP_OKAY);
        pll_clock_option <= 1'b1;
        repeat (4) @(posedge aclk);
        chkb("pll_sel", 1'b1, pll_clock_selected);
        wreg(RA, 8'h88, RESP_OKAY);
        chkb("pll_sel", 1'b1, pll_clock_selected);
        end_sim();
    end
endmodule : tb_system_integrity_ctrl_status
